// ---- pcc_pkg.sv ----
// Constants shared by the front-panel counter clear menu.
// Function
// - Offer a menu function that zeroes the command pulse counter.
// - Offer a second function that zeroes all three encoder feedback monitors.
// - Clearing only happens while parameter write protection is off.
// - Mode key enters function list; up and down step function numbers.
// - Holding data/shift about one second on function 301 or 302 opens the confirmation screen.
// - Up key advances the token until the armed token appears.
// - Mode key on armed token clears the selected function's counters.
// - After the completion blink the armed token is shown again.
// - Data/shift on the confirmation screen returns to the function number.
`default_nettype none
package pcc_pkg;
    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int HOLD_TIME_MS = 1000;
    localparam int DONE_TIME_MS = 1000;
    localparam int BLINK_TIME_MS = 250;
    localparam int NOOP_TIME_MS = 1000;
    localparam int HOLD_CYCLES = HOLD_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DONE_CYCLES = DONE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BLINK_CYCLES = BLINK_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int NOOP_CYCLES = NOOP_TIME_MS * 1000000 / CLK_PERIOD_NS;
    // ==========================================
    // Function numbers in the auxiliary list
    localparam logic [11:0] FN_AUX_ENTRY = 12'h000;
    localparam logic [11:0] FN_WRITE_PROTECT = 12'h010;
    localparam logic [11:0] FN_POS_CLEAR = 12'h301;
    localparam logic [11:0] FN_ENC_CLEAR = 12'h302;
    localparam logic [1:0] FN_LIST_LAST = 2'h3;
    // ==========================================
    // Confirmation tokens
    localparam logic [1:0] TOKEN_CLEAR_SYMBOL = 2'h0;
    localparam logic [1:0] TOKEN_ARMED = 2'h2;
    // ==========================================
    // Display content kinds
    localparam logic [2:0] DISP_MONITOR = 3'h0;
    localparam logic [2:0] DISP_FUNC = 3'h1;
    localparam logic [2:0] DISP_TOKEN = 3'h2;
    localparam logic [2:0] DISP_DONE = 3'h3;
    localparam logic [2:0] DISP_NOOP = 3'h4;
    // ==========================================
    // Reset value and counter sizes
    localparam logic [1:0] FN_INDEX_RESET = 2'h0;
    localparam int COUNT_WIDTH = 32;
    localparam int ENC_PULSES_PER_REV = 1024;

    typedef enum logic [4:0] {
        ST_MONITOR = 5'h01,
        ST_FUNC_LIST = 5'h02,
        ST_CONFIRM = 5'h04,
        ST_DONE = 5'h08,
        ST_NOOP = 5'h10
    } pcc_state_t;

    function automatic logic [11:0] fn_code(input logic [1:0] idx);
        unique case (idx)
            2'h0: fn_code = FN_AUX_ENTRY;
            2'h1: fn_code = FN_WRITE_PROTECT;
            2'h2: fn_code = FN_POS_CLEAR;
            default: fn_code = FN_ENC_CLEAR;
        endcase
    endfunction : fn_code
endpackage : pcc_pkg
`default_nettype wire

// ---- pcc_timer.sv ----
// Restartable interval counter that pulses once per elapsed interval.
`default_nettype none
module pcc_timer #(
    parameter int LIMIT = 1000
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    output logic expired
);
    localparam int W = (LIMIT > 1) ? $clog2(LIMIT) : 1;
    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    logic [W-1:0] count_r;
    wire at_last = (count_r == LAST);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_r <= '0;
        else if (!run || at_last)
            count_r <= '0;
        else
            count_r <= count_r + W'(1);
    end

    assign expired = run && at_last;
endmodule : pcc_timer
`default_nettype wire

// ---- pcc_menu.sv ----
// Front-panel menu that zeroes the command pulse and encoder feedback counters.
`default_nettype none
module pcc_menu #(
    parameter int HOLD_CYCLES = pcc_pkg::HOLD_CYCLES,
    parameter int DONE_CYCLES = pcc_pkg::DONE_CYCLES,
    parameter int BLINK_CYCLES = pcc_pkg::BLINK_CYCLES,
    parameter int NOOP_CYCLES = pcc_pkg::NOOP_CYCLES,
    parameter int CW = pcc_pkg::COUNT_WIDTH,
    parameter int PPR = pcc_pkg::ENC_PULSES_PER_REV
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic key_mode,
    input wire logic key_shift,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic write_protect,
    input wire logic cmd_pulse,
    input wire logic enc_pulse,
    input wire logic enc_dir,
    output logic [2:0] disp_kind_r,
    output logic [11:0] disp_fn_r,
    output logic [1:0] disp_token_r,
    output logic disp_blink_r,
    output logic [CW-1:0] command_pulse_count_monitor,
    output logic [CW-1:0] encoder_feedback_monitor_a,
    output logic [CW-1:0] encoder_feedback_monitor_b,
    output logic [CW-1:0] encoder_feedback_monitor_c
);
    // ==========================================
    // Key edges
    logic mode_q_r, shift_q_r, up_q_r, down_q_r;
    wire mode_edge = key_mode && !mode_q_r;
    wire shift_edge = key_shift && !shift_q_r;
    wire up_edge = key_up && !up_q_r;
    wire down_edge = key_down && !down_q_r;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q_r <= 1'b0;
            shift_q_r <= 1'b0;
            up_q_r <= 1'b0;
            down_q_r <= 1'b0;
        end
        else
        begin
            mode_q_r <= key_mode;
            shift_q_r <= key_shift;
            up_q_r <= key_up;
            down_q_r <= key_down;
        end
    end

    // ==========================================
    // State and selection
    pcc_pkg::pcc_state_t state_r, state_nxt;
    logic [1:0] fn_idx_r, fn_idx_nxt;
    logic [1:0] token_r, token_nxt;
    logic blink_nxt;

    wire [11:0] sel_fn = pcc_pkg::fn_code(fn_idx_r);
    wire sel_is_pos = (sel_fn == pcc_pkg::FN_POS_CLEAR);
    wire sel_is_enc = (sel_fn == pcc_pkg::FN_ENC_CLEAR);
    wire sel_is_clear = sel_is_pos || sel_is_enc;
    wire in_list = (state_r == pcc_pkg::ST_FUNC_LIST);
    wire in_confirm = (state_r == pcc_pkg::ST_CONFIRM);
    wire in_done = (state_r == pcc_pkg::ST_DONE);
    wire in_noop = (state_r == pcc_pkg::ST_NOOP);

    wire clear_allowed = (token_r == pcc_pkg::TOKEN_ARMED) && !write_protect;
    wire do_clear = in_confirm && mode_edge && !shift_edge && clear_allowed;
    wire clear_pos = do_clear && sel_is_pos;
    wire clear_enc = do_clear && sel_is_enc;

    // ==========================================
    // Timers
    logic hold_expired, done_expired, blink_expired, noop_expired;
    wire hold_run = in_list && key_shift && sel_is_clear;

    pcc_timer #(.LIMIT(HOLD_CYCLES)) u_hold (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(hold_run),
        .expired(hold_expired)
    );

    pcc_timer #(.LIMIT(DONE_CYCLES)) u_done (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(in_done),
        .expired(done_expired)
    );

    pcc_timer #(.LIMIT(BLINK_CYCLES)) u_blink (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(in_done),
        .expired(blink_expired)
    );

    pcc_timer #(.LIMIT(NOOP_CYCLES)) u_noop (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(in_noop),
        .expired(noop_expired)
    );

    // ==========================================
    // Next state
    always_comb
    begin
        state_nxt = state_r;
        fn_idx_nxt = fn_idx_r;
        token_nxt = token_r;
        blink_nxt = disp_blink_r;
        unique case (state_r)
            pcc_pkg::ST_MONITOR:
            begin
                if (mode_edge)
                begin
                    state_nxt = pcc_pkg::ST_FUNC_LIST;
                    fn_idx_nxt = pcc_pkg::FN_INDEX_RESET;
                end
            end
            pcc_pkg::ST_FUNC_LIST:
            begin
                if (up_edge && fn_idx_r != pcc_pkg::FN_LIST_LAST)
                    fn_idx_nxt = fn_idx_r + 2'h1;
                else if (down_edge && fn_idx_r != 2'h0)
                    fn_idx_nxt = fn_idx_r - 2'h1;
                if (hold_expired)
                begin
                    state_nxt = pcc_pkg::ST_CONFIRM;
                    token_nxt = pcc_pkg::TOKEN_CLEAR_SYMBOL;
                end
                else if (mode_edge)
                    state_nxt = pcc_pkg::ST_MONITOR;
            end
            pcc_pkg::ST_CONFIRM:
            begin
                if (shift_edge)
                    state_nxt = pcc_pkg::ST_FUNC_LIST;
                else if (mode_edge)
                begin
                    if (clear_allowed)
                    begin
                        state_nxt = pcc_pkg::ST_DONE;
                        blink_nxt = 1'b1;
                    end
                    else
                        state_nxt = pcc_pkg::ST_NOOP;
                end
                else if (up_edge)
                    token_nxt = token_r + 2'h1;
                else if (down_edge)
                    token_nxt = token_r - 2'h1;
            end
            pcc_pkg::ST_DONE:
            begin
                if (blink_expired)
                    blink_nxt = !disp_blink_r;
                if (done_expired)
                begin
                    state_nxt = pcc_pkg::ST_CONFIRM;
                    token_nxt = pcc_pkg::TOKEN_ARMED;
                    blink_nxt = 1'b0;
                end
            end
            pcc_pkg::ST_NOOP:
            begin
                if (noop_expired)
                    state_nxt = pcc_pkg::ST_CONFIRM;
            end
            default:
                state_nxt = pcc_pkg::ST_MONITOR;
        endcase
    end

    // ==========================================
    // Display content
    logic [2:0] kind_nxt;
    always_comb
    begin
        unique case (state_nxt)
            pcc_pkg::ST_FUNC_LIST: kind_nxt = pcc_pkg::DISP_FUNC;
            pcc_pkg::ST_CONFIRM: kind_nxt = pcc_pkg::DISP_TOKEN;
            pcc_pkg::ST_DONE: kind_nxt = pcc_pkg::DISP_DONE;
            pcc_pkg::ST_NOOP: kind_nxt = pcc_pkg::DISP_NOOP;
            default: kind_nxt = pcc_pkg::DISP_MONITOR;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= pcc_pkg::ST_MONITOR;
            fn_idx_r <= pcc_pkg::FN_INDEX_RESET;
            token_r <= pcc_pkg::TOKEN_CLEAR_SYMBOL;
            disp_kind_r <= pcc_pkg::DISP_MONITOR;
            disp_fn_r <= pcc_pkg::FN_AUX_ENTRY;
            disp_token_r <= pcc_pkg::TOKEN_CLEAR_SYMBOL;
            disp_blink_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            fn_idx_r <= fn_idx_nxt;
            token_r <= token_nxt;
            disp_kind_r <= kind_nxt;
            disp_fn_r <= pcc_pkg::fn_code(fn_idx_nxt);
            disp_token_r <= token_nxt;
            disp_blink_r <= blink_nxt;
        end
    end

    // ==========================================
    // Counters
    localparam logic [CW-1:0] LAST_IN_REV = CW'(PPR - 1);
    wire wrap_up = enc_dir && (encoder_feedback_monitor_b == LAST_IN_REV);
    wire wrap_down = !enc_dir && (encoder_feedback_monitor_b == '0);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            command_pulse_count_monitor <= '0;
        else if (clear_pos)
            command_pulse_count_monitor <= '0;
        else if (cmd_pulse)
            command_pulse_count_monitor <= command_pulse_count_monitor + CW'(1);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            encoder_feedback_monitor_a <= '0;
            encoder_feedback_monitor_b <= '0;
            encoder_feedback_monitor_c <= '0;
        end
        else if (clear_enc)
        begin
            encoder_feedback_monitor_a <= '0;
            encoder_feedback_monitor_b <= '0;
            encoder_feedback_monitor_c <= '0;
        end
        else if (enc_pulse)
        begin
            encoder_feedback_monitor_a <= enc_dir ? encoder_feedback_monitor_a + CW'(1)
                                                  : encoder_feedback_monitor_a - CW'(1);
            if (wrap_up)
            begin
                encoder_feedback_monitor_b <= '0;
                encoder_feedback_monitor_c <= encoder_feedback_monitor_c + CW'(1);
            end
            else if (wrap_down)
            begin
                encoder_feedback_monitor_b <= LAST_IN_REV;
                encoder_feedback_monitor_c <= encoder_feedback_monitor_c - CW'(1);
            end
            else
                encoder_feedback_monitor_b <= enc_dir ? encoder_feedback_monitor_b + CW'(1)
                                                      : encoder_feedback_monitor_b - CW'(1);
        end
    end
endmodule : pcc_menu
`default_nettype wire

// ---- pcc_menu_sva.sv ----
// Port assertions for the counter clear menu.
`default_nettype none
module pcc_menu_sva #(
    parameter int HOLD_CYCLES = 20,
    parameter int DONE_CYCLES = 40,
    parameter int CW = 32
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic key_mode,
    input wire logic key_shift,
    input wire logic write_protect,
    input wire logic cmd_pulse,
    input wire logic [2:0] disp_kind_r,
    input wire logic [11:0] disp_fn_r,
    input wire logic [1:0] disp_token_r,
    input wire logic disp_blink_r,
    input wire logic [CW-1:0] command_pulse_count_monitor,
    input wire logic [CW-1:0] encoder_feedback_monitor_a,
    input wire logic [CW-1:0] encoder_feedback_monitor_b,
    input wire logic [CW-1:0] encoder_feedback_monitor_c
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] done_cnt_r;
    logic [31:0] hold_cnt_r;
    logic in_done;
    logic in_tok;
    assign in_done = disp_kind_r == pcc_pkg::DISP_DONE;
    assign in_tok = disp_kind_r == pcc_pkg::DISP_TOKEN;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_cnt_r <= 32'h0;
            hold_cnt_r <= 32'h0;
        end
        else
        begin
            done_cnt_r <= in_done ? done_cnt_r + 32'h1 : 32'h0;
            hold_cnt_r <= key_shift ? hold_cnt_r + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    chk_pos_zeroed: assert property ($rose(in_done) && disp_fn_r == pcc_pkg::FN_POS_CLEAR
        |-> command_pulse_count_monitor == '0) else $error("command counter not zeroed");
    chk_enc_zeroed: assert property ($rose(in_done) && disp_fn_r == pcc_pkg::FN_ENC_CLEAR
        |-> (encoder_feedback_monitor_a | encoder_feedback_monitor_b | encoder_feedback_monitor_c) == '0)
        else $error("encoder counters not zeroed");
    chk_protect_blocks: assert property ($rose(in_done) |-> !$past(write_protect))
        else $error("clear taken while protected");
    chk_armed_only: assert property ($rose(in_done) |-> $past(in_tok)
        && $past(disp_token_r) == pcc_pkg::TOKEN_ARMED && disp_blink_r) else $error("clear without armed token");
    chk_done_length: assert property ($fell(in_done)
        |-> done_cnt_r >= DONE_CYCLES - 1 && done_cnt_r <= DONE_CYCLES + 1) else $error("done word length");
    chk_back_armed: assert property ($fell(in_done)
        |-> in_tok && disp_token_r == pcc_pkg::TOKEN_ARMED) else $error("no armed token after done");
    chk_shift_exit: assert property (in_tok && key_shift && !$past(key_shift)
        |=> disp_kind_r == pcc_pkg::DISP_FUNC) else $error("shift did not leave confirm");
    chk_refuse_noop: assert property (in_tok && key_mode && !$past(key_mode) && !key_shift
        && disp_token_r != pcc_pkg::TOKEN_ARMED |=> disp_kind_r == pcc_pkg::DISP_NOOP) else $error("no no-op shown");
    chk_hold_entry: assert property ($rose(in_tok) && $past(disp_kind_r) == pcc_pkg::DISP_FUNC
        |-> disp_token_r == pcc_pkg::TOKEN_CLEAR_SYMBOL && hold_cnt_r >= HOLD_CYCLES - 1)
        else $error("confirm entered without hold");
    chk_count_step: assert property (!in_tok && cmd_pulse
        |=> command_pulse_count_monitor == $past(command_pulse_count_monitor) + 1'b1) else $error("count step");
endmodule : pcc_menu_sva
bind pcc_menu pcc_menu_sva #(.HOLD_CYCLES(HOLD_CYCLES), .DONE_CYCLES(DONE_CYCLES), .CW(CW)) u_sva (
    .core_clk, .rst_n, .key_mode, .key_shift, .write_protect, .cmd_pulse, .disp_kind_r, .disp_fn_r,
    .disp_token_r, .disp_blink_r, .command_pulse_count_monitor, .encoder_feedback_monitor_a,
    .encoder_feedback_monitor_b, .encoder_feedback_monitor_c
);
`default_nettype wire

// ---- pcc_operator.sv ----
// Operator model pressing one panel key for a set number of cycles.
`default_nettype none
module pcc_operator (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [1:0] sel,
    input wire logic [7:0] len,
    output logic key_mode,
    output logic key_shift,
    output logic key_up,
    output logic key_down,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r = 8'h00;
    logic [3:0] keys_r = 4'h0;
    assign busy = cnt_r != 8'h00;
    assign {key_down, key_up, key_shift, key_mode} = keys_r;
    // Falling-edge changes, idle gap between presses
    always @(negedge core_clk)
    begin
        if (busy)
        begin
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h01)
                keys_r <= 4'h0;
        end
        else if (go)
        begin
            cnt_r <= len + 8'h01;
            keys_r <= 4'h1 << sel;
        end
    end
endmodule : pcc_operator
`default_nettype wire

// ---- pcc_menu_tb_top.sv ----
// Self-checking bench for the counter clear menu.
`default_nettype none
module pcc_menu_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] KM = 2'h0, KS = 2'h1, KU = 2'h2, KD = 2'h3;
    logic core_clk, rst_n, write_protect, cmd_pulse, enc_pulse, enc_dir, go, busy;
    logic key_mode, key_shift, key_up, key_down, blink;
    logic [1:0] sel, tok;
    logic [7:0] len;
    logic [2:0] kind;
    logic [11:0] fn;
    logic [31:0] cnt, ea, eb, ec;
    int fail_count, checks_done;
    pcc_menu #(.HOLD_CYCLES(20), .DONE_CYCLES(40), .BLINK_CYCLES(5), .NOOP_CYCLES(10), .PPR(8)) dut (
        .core_clk, .rst_n, .key_mode, .key_shift, .key_up, .key_down, .write_protect, .cmd_pulse,
        .enc_pulse, .enc_dir, .disp_kind_r(kind), .disp_fn_r(fn), .disp_token_r(tok),
        .disp_blink_r(blink), .command_pulse_count_monitor(cnt), .encoder_feedback_monitor_a(ea),
        .encoder_feedback_monitor_b(eb), .encoder_feedback_monitor_c(ec));
    pcc_operator op (.core_clk, .go, .sel, .len, .key_mode, .key_shift, .key_up, .key_down, .busy);
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic press(input logic [1:0] k, input logic [7:0] n);
        int w;
        @(posedge core_clk);
        sel <= k;
        len <= n;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        for (w = 0; busy && w < 300; w++)
            @(posedge core_clk);
        if (busy)
        begin
            fail_count++;
            $display("wrong value at %0t: key press never ended", $time);
            give_verdict();
        end
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask : press
    task automatic pulses(input int n);
        cmd_pulse = 1'b1;
        enc_pulse = 1'b1;
        repeat (n) @(negedge core_clk);
        cmd_pulse = 1'b0;
        enc_pulse = 1'b0;
    endtask : pulses
    task automatic wait_token();
        int w;
        for (w = 0; kind !== pcc_pkg::DISP_TOKEN && w < 200; w++)
            @(negedge core_clk);
        check({29'h0, kind}, {29'h0, pcc_pkg::DISP_TOKEN}, "back to token");
        if (kind !== pcc_pkg::DISP_TOKEN)
            give_verdict();
    endtask : wait_token
    task automatic arm_and_clear();
        press(KS, 8'd23);
        check({30'h0, tok}, 32'h0, "clear symbol");
        press(KU, 8'd1);
        press(KU, 8'd1);
        check({30'h0, tok}, 32'h2, "armed token");
        press(KM, 8'd1);
        check({29'h0, kind}, 32'h3, "done word");
        check({31'h0, blink}, 32'h1, "blink lit");
        @(negedge core_clk);
        check({31'h0, blink}, 32'h0, "blink toggled");
    endtask : arm_and_clear
    task automatic t_nav();
        press(KM, 8'd1);
        press(KD, 8'd1);
        check({20'h0, fn}, 32'h000, "list floor");
        repeat (4) press(KU, 8'd1);
        check({20'h0, fn}, 32'h302, "list top");
        press(KD, 8'd1);
        press(KS, 8'd15);
        check({29'h0, kind}, 32'h1, "short hold ignored");
    endtask : t_nav
    task automatic t_pos();
        pulses(5);
        check(cnt, 32'd5, "count before");
        arm_and_clear();
        check(cnt, 32'h0, "command cleared");
        check(ea, 32'd5, "encoder kept");
        wait_token();
        check({30'h0, tok}, 32'h2, "armed after done");
        pulses(3);
        check(cnt, 32'd3, "resume from zero");
        press(KS, 8'd1);
        check({20'h0, fn}, 32'h301, "exit to number");
    endtask : t_pos
    task automatic t_enc();
        press(KU, 8'd1);
        pulses(10);
        check({ea, eb, ec} == {32'd18, 32'd2, 32'd2}, 1, "encoder before");
        arm_and_clear();
        check(ea | eb | ec, 32'h0, "encoder cleared");
        check(cnt, 32'd13, "command kept");
        wait_token();
    endtask : t_enc
    task automatic t_refuse();
        pulses(2);
        write_protect = 1'b1;
        press(KM, 8'd1);
        check({29'h0, kind}, 32'h4, "protected no-op");
        wait_token();
        write_protect = 1'b0;
        press(KU, 8'd1);
        press(KM, 8'd1);
        check({29'h0, kind}, 32'h4, "wrong token no-op");
        wait_token();
        check({30'h0, tok}, 32'h3, "token kept");
        check(ea, 32'd2, "counters kept");
        enc_dir = 1'b0;
        pulses(3);
        check({ea, eb, ec} == {32'hFFFFFFFF, 32'h7, 32'hFFFFFFFF}, 1, "reverse wrap");
    endtask : t_refuse
    initial
    begin
        {rst_n, write_protect, cmd_pulse, enc_pulse, go, sel, len} = '0;
        enc_dir = 1'b1;
        fail_count = 0;
        checks_done = 0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        t_nav();
        t_pos();
        t_enc();
        t_refuse();
        give_verdict();
    end
endmodule : pcc_menu_tb_top
`default_nettype wire
